// >>> include/palp_consts.svh
// Offsets, field positions, reset values and timing counts of the port register set.
// Assumes a 10 MHz system clock; included by the package users by bare name.
`ifndef PALP_CONSTS_SVH
`define PALP_CONSTS_SVH
`define PALP_OFS_FIBER_CTRL 5'h10
`define PALP_OFS_GOOD_CRC 5'h12
`define PALP_OFS_AUX 5'h1C
`define PALP_OFS_LED_MODE 5'h1D
`define PALP_OFS_LED_BEHAV 5'h1E
`define PALP_OFS_PAGE 5'h1F
`define PALP_PAGE_MAIN 16'h0000
`define PALP_PAGE_EXT1 16'h0001
`define PALP_PAGE_EXT3 16'h0003
`define PALP_PAGE_GPIO 16'h0010
`define PALP_LED_MODE_RST 16'h8021
`define PALP_LED_BEHAV_RST 16'h0400
`define PALP_LED_BEHAV_MASK 16'h1C63
`define PALP_AUX_STICKY_RST 3'h1
`define PALP_FIBER_ALLOW_RST 2'h3
`define PALP_CRC_MODULUS 14'h270F
`define PALP_CLK_HZ 10000000
`define PALP_PULSE_HZ 5000
`define PALP_PULSE_CYC (`PALP_CLK_HZ / `PALP_PULSE_HZ)
// Half period of the fastest (20 Hz) blink in ms; slower rates double it.
`define PALP_BLINK_BASE_MS 25
`define PALP_STRETCH_BASE_MS 50
`define PALP_MS_CYC (`PALP_CLK_HZ / 1000)
`endif

// >>> include/palp_pkg.sv
// Types of the port register set: link status carrier and page codes.
// Assumes palp_consts.svh holds the numbers.
package palp_pkg;
  typedef struct packed {
    logic anComplete;
    logic anEnable;
    logic crossover;
    logic pairCdSwap;
    logic [3:0] polaritySwap;
    logic duplexStatus;
    logic [1:0] speed;
    logic [1:0] media;
  } palp_link_type;
  typedef enum logic [3:0] {
    PG_MAIN = 4'h1,
    PG_EXT1 = 4'h2,
    PG_EXTO = 4'h4,
    PG_GPIO = 4'h8
  } palp_page_type;
endpackage

// >>> core/palp_regs.sv
// Per-port management registers: auxiliary status, LED control, page select,
// fiber media control and good-CRC counter, plus the LED blink and pulse timing.
// Assumes a 10 MHz clock and a single-cycle strobe register port from the station manager.
`timescale 1ns/1ps
`include "palp_consts.svh"
module palp_regs #(
  parameter bit IS_PORT0 = 1'b1,
  parameter bit HAS_FIBER = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // Software reset, register 0 bit 15 of the standard block
  input wire logic softReset,
  // Link state from the transceiver core
  input wire palp_pkg::palp_link_type linkState,
  input wire logic goodCrcPacket,
  input wire logic farEndFault,
  input wire logic [1:0] partnerRemoteFault,
  // Standard-space decode for registers 0-15 and other pages
  output logic stdSpaceSel,
  output logic gpioPageSel,
  // Rate taken from port 0 and used by every port
  input wire logic [1:0] globalRate,
  output logic [1:0] localRate,
  // LED activity inputs
  input wire logic [3:0] ledActive,
  input wire logic [1:0] ledActivity,
  input wire logic [1:0] ledCombineTerm,
  output logic [3:0] ledOut,
  // Controls toward the core
  output logic [15:0] ledModeSel,
  output logic lowPowerEnable,
  output logic [1:0] lowPowerTimeout,
  output logic [1:0] txRemoteFault,
  output logic allowFiber1000,
  output logic allowFiber100,
  output logic [1:0] combineDisable,
  output logic [15:0] pageValue
);
  logic [15:0] pageQ;
  logic [2:0] auxStickyQ;
  logic [15:0] ledModeQ;
  logic [15:0] ledBehavQ;
  logic [1:0] txFaultQ;
  logic [1:0] fiberAllowQ;
  logic farFaultQ;
  logic crcSeenQ;
  logic [13:0] crcCountQ;
  logic [15:0] rdDataQ;
  logic [15:0] pulseCntQ;
  logic [23:0] blinkCntQ;
  logic blinkPhaseQ;
  palp_pkg::palp_page_type pageKind;

  // Page decode: GPIO page takes 0-30, extended pages only 16-30.
  wire isReg31 = (regAddr == `PALP_OFS_PAGE);
  wire upperReg = regAddr[4];
  assign pageKind = (pageQ == `PALP_PAGE_MAIN) ? palp_pkg::PG_MAIN :
                    (pageQ == `PALP_PAGE_EXT1) ? palp_pkg::PG_EXT1 :
                    (pageQ == `PALP_PAGE_GPIO) ? palp_pkg::PG_GPIO : palp_pkg::PG_EXTO;
  wire mainHit = !isReg31 && upperReg && (pageKind == palp_pkg::PG_MAIN);
  wire ext1Hit = !isReg31 && upperReg && (pageKind == palp_pkg::PG_EXT1);
  assign stdSpaceSel = !isReg31 && !upperReg && (pageKind != palp_pkg::PG_GPIO);
  assign gpioPageSel = !isReg31 && (pageKind == palp_pkg::PG_GPIO);
  assign pageValue = pageQ;

  wire selAux = mainHit && (regAddr == `PALP_OFS_AUX);
  wire selLedMode = mainHit && (regAddr == `PALP_OFS_LED_MODE);
  wire selLedBehav = mainHit && (regAddr == `PALP_OFS_LED_BEHAV);
  wire selFiber = ext1Hit && (regAddr == `PALP_OFS_FIBER_CTRL) && HAS_FIBER;
  wire selCrc = ext1Hit && (regAddr == `PALP_OFS_GOOD_CRC);

  wire [15:0] auxView = {linkState.anComplete, !linkState.anEnable,
                         linkState.crossover, linkState.pairCdSwap,
                         linkState.polaritySwap,
                         auxStickyQ[2], auxStickyQ[1],
                         linkState.duplexStatus,
                         linkState.speed,
                         auxStickyQ[0], linkState.media};
  wire [15:0] fiberView = {txFaultQ, partnerRemoteFault, 2'h0, fiberAllowQ, 1'b0, farFaultQ, 6'h00};
  wire [15:0] crcView = {crcSeenQ, 1'b0, crcCountQ};
  wire [15:0] rdMux = isReg31 ? pageQ :
                      selAux ? auxView :
                      selLedMode ? ledModeQ :
                      selLedBehav ? (ledBehavQ & `PALP_LED_BEHAV_MASK) :
                      selFiber ? fiberView :
                      selCrc ? crcView : 16'h0000;

  wire rdFiber = regRead && selFiber;
  wire rdCrc = regRead && selCrc;

  assign lowPowerTimeout = {auxStickyQ[2], auxStickyQ[0]};
  assign lowPowerEnable = auxStickyQ[1];
  assign ledModeSel = ledModeQ;
  assign localRate = ledBehavQ[11:10];
  assign combineDisable = ledBehavQ[1:0];
  assign txRemoteFault = HAS_FIBER ? txFaultQ : 2'h0;
  assign allowFiber1000 = HAS_FIBER && fiberAllowQ[1];
  assign allowFiber100 = HAS_FIBER && fiberAllowQ[0];
  assign regRdData = rdDataQ;

  // Page register and read data; page is not sticky and returns to main on software reset.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pageQ <= 16'h0000;
      rdDataQ <= 16'h0000;
    end else begin
      rdDataQ <= regRead ? rdMux : 16'h0000;
      if (softReset) begin
        pageQ <= `PALP_PAGE_MAIN;
      end else if (regWrite && isReg31) begin
        pageQ <= regWrData;
      end
    end
  end

  // Sticky fields see only the hardware reset, never softReset.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      auxStickyQ <= `PALP_AUX_STICKY_RST;
      ledModeQ <= `PALP_LED_MODE_RST;
      ledBehavQ <= `PALP_LED_BEHAV_RST;
      fiberAllowQ <= `PALP_FIBER_ALLOW_RST;
    end else if (regWrite) begin
      if (selAux) begin
        auxStickyQ <= {regWrData[7], regWrData[6], regWrData[2]};
      end
      if (selLedMode) begin
        ledModeQ <= regWrData;
      end
      if (selLedBehav) begin
        ledBehavQ <= regWrData & `PALP_LED_BEHAV_MASK;
      end
      if (selFiber) begin
        fiberAllowQ <= regWrData[9:8];
      end
    end
  end

  // Non-sticky fiber fields and the event flags; an event in the read cycle wins.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txFaultQ <= 2'h0;
      farFaultQ <= 1'b0;
      crcSeenQ <= 1'b0;
      crcCountQ <= 14'h0000;
    end else begin
      if (softReset) begin
        txFaultQ <= 2'h0;
      end else if (regWrite && selFiber) begin
        txFaultQ <= regWrData[15:14];
      end
      farFaultQ <= (HAS_FIBER && farEndFault) || (farFaultQ && !rdFiber);
      crcSeenQ <= goodCrcPacket || (crcSeenQ && !rdCrc);
      if (goodCrcPacket) begin
        if (rdCrc || crcCountQ == `PALP_CRC_MODULUS) begin
          crcCountQ <= 14'h0001 & {14{rdCrc}};
        end else begin
          crcCountQ <= crcCountQ + 14'h0001;
        end
      end else if (rdCrc) begin
        crcCountQ <= 14'h0000;
      end
    end
  end

  // LED timing. The port 0 instance drives the shared rate.
  wire [1:0] effRate = IS_PORT0 ? ledBehavQ[11:10] : globalRate;
  wire [23:0] blinkHalf = 24'(`PALP_BLINK_BASE_MS * `PALP_MS_CYC) << (2'h3 - effRate);
  wire [23:0] stretchLen = 24'(`PALP_STRETCH_BASE_MS * `PALP_MS_CYC) << (2'h3 - effRate);
  wire pulseOn = pulseCntQ < 16'(`PALP_PULSE_CYC / 2);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pulseCntQ <= 16'h0000;
      blinkCntQ <= 24'h000000;
      blinkPhaseQ <= 1'b0;
    end else begin
      pulseCntQ <= (pulseCntQ == 16'(`PALP_PULSE_CYC - 1)) ? 16'h0000 : pulseCntQ + 16'h0001;
      if (blinkCntQ >= blinkHalf - 24'h000001) begin
        blinkCntQ <= 24'h000000;
        blinkPhaseQ <= !blinkPhaseQ;
      end else begin
        blinkCntQ <= blinkCntQ + 24'h000001;
      end
    end
  end

  // Activity shaping for LED0 and LED1; the other LEDs follow their active level.
  // Each slice keeps its own stretch state, so no variable has two writing processes.
  wire [3:0] ledNext;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gActivity
      logic [23:0] stretchCntQ;
      logic stretchQ;
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          stretchCntQ <= 24'h000000;
          stretchQ <= 1'b0;
        end else begin
          if (ledActivity[g]) begin
            stretchCntQ <= stretchLen;
          end else if (stretchCntQ != 24'h000000) begin
            stretchCntQ <= stretchCntQ - 24'h000001;
          end
          stretchQ <= ledActivity[g] || (stretchCntQ > 24'h000001);
        end
      end
      wire actShown = ledBehavQ[5 + g] ? stretchQ : (ledActivity[g] && blinkPhaseQ);
      wire combined = ledBehavQ[g] ? ledActive[g] : (ledActive[g] && !actShown) || ledCombineTerm[g];
      assign ledNext[g] = combined && (!ledBehavQ[12] || pulseOn);
    end
    for (g = 2; g < 4; g++) begin : gPlain
      assign ledNext[g] = ledActive[g] && (!ledBehavQ[12] || pulseOn);
    end
  endgenerate

  // One register stage for all four LEDs, so the pins never show decode glitches.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ledOut <= 4'h0;
    end else begin
      ledOut <= ledNext;
    end
  end

  a_aux_mirror: assert property (@(posedge sys_clk) disable iff (!rstn)
    regRead && selAux |=> regRdData[15:14] == $past({linkState.anComplete, !linkState.anEnable}))
    else $error("aux bits 15:14 do not mirror autonegotiation state");
  a_aux_status: assert property (@(posedge sys_clk) disable iff (!rstn)
    regRead && selAux |=> regRdData[13:8] == $past({linkState.crossover, linkState.pairCdSwap, linkState.polaritySwap}))
    else $error("aux pair status wrong");
  a_aux_speed: assert property (@(posedge sys_clk) disable iff (!rstn)
    regRead && selAux |=> regRdData[5:3] == $past({linkState.duplexStatus, linkState.speed}))
    else $error("aux duplex or speed wrong");
  a_aux_media: assert property (@(posedge sys_clk) disable iff (!rstn)
    regRead && selAux |=> regRdData[1:0] == $past(linkState.media))
    else $error("aux media wrong");
  a_sticky_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
    softReset && !regWrite |=> $stable(ledModeQ) && $stable(auxStickyQ) && $stable(fiberAllowQ))
    else $error("sticky field changed on software reset");
  a_crc_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    goodCrcPacket && !rdCrc && crcCountQ == 14'h270F |=> crcCountQ == 14'h0000)
    else $error("good CRC counter did not wrap");
  a_far_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    rdFiber && !farEndFault |=> !farFaultQ)
    else $error("far-end fault not cleared by read");
  a_page_low: assert property (@(posedge sys_clk) disable iff (!rstn)
    !regAddr[4] && pageKind != palp_pkg::PG_GPIO |-> stdSpaceSel)
    else $error("low registers left standard space");
  a_pulse_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    ledBehavQ[12] && !pulseOn |=> ledOut[3:2] == 2'b00)
    else $error("LED on outside pulse window");

  // Auxiliary register fields that the broad checks above do not single out.
  a_aux_negate: assert property (@(posedge sys_clk) disable iff (!rstn)
    regRead && selAux |=> regRdData[14] == !$past(linkState.anEnable))
    else $error("aux bit 14 is not the inverted enable");
  a_aux_polarity: assert property (@(posedge sys_clk) disable iff (!rstn)
    regRead && selAux |=> regRdData[11:8] == $past(linkState.polaritySwap))
    else $error("aux polarity bits wrong");
  a_aux_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
    regRead && selAux |=> {regRdData[7:6], regRdData[2]} == $past(auxStickyQ))
    else $error("aux low-power fields wrong");
  a_aux_duplex: assert property (@(posedge sys_clk) disable iff (!rstn)
    regRead && selAux |=> regRdData[5] == $past(linkState.duplexStatus))
    else $error("aux duplex bit wrong");

  // LED control and timing.
  a_led_mode: assert property (@(posedge sys_clk) disable iff (!rstn)
    regWrite && selLedMode |=> ledModeQ == $past(regWrData))
    else $error("LED mode write lost");
  a_pulse_pass: assert property (@(posedge sys_clk) disable iff (!rstn)
    !ledBehavQ[12] |=> ledOut[3:2] == $past(ledActive[3:2]))
    else $error("steady LED does not follow its level");
  a_pulse_period: assert property (@(posedge sys_clk) disable iff (!rstn)
    pulseCntQ == 16'(`PALP_PULSE_CYC - 1) |=> pulseCntQ == 16'h0000)
    else $error("pulse period counter did not wrap");
  a_behav_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    regWrite && selLedBehav |=> ledBehavQ == ($past(regWrData) & `PALP_LED_BEHAV_MASK))
    else $error("LED behaviour write wrong");
  a_blink_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    blinkCntQ >= blinkHalf - 24'h000001 |=> blinkCntQ == 24'h000000)
    else $error("blink counter did not restart");
  a_rate_fast: assert property (@(posedge sys_clk) disable iff (!rstn)
    IS_PORT0 && ledBehavQ[11:10] == 2'h3 |-> blinkHalf == 24'h03D090)
    else $error("port 0 rate field not applied");
  a_led0_stretch: assert property (@(posedge sys_clk) disable iff (!rstn)
    ledActivity[0] |=> gActivity[0].stretchQ)
    else $error("LED0 activity not stretched");
  a_led1_stretch: assert property (@(posedge sys_clk) disable iff (!rstn)
    ledActivity[1] |=> gActivity[1].stretchQ)
    else $error("LED1 activity not stretched");
  a_combine_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    ledBehavQ[0] && !ledBehavQ[12] |=> ledOut[0] == $past(ledActive[0]))
    else $error("LED0 combining not disabled");

  // Page selection.
  a_page_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    regWrite && isReg31 && !softReset |=> pageQ == $past(regWrData))
    else $error("page write lost");
  a_gpio_sel: assert property (@(posedge sys_clk) disable iff (!rstn)
    pageKind == palp_pkg::PG_GPIO && !isReg31 |-> gpioPageSel && !stdSpaceSel)
    else $error("GPIO page decode wrong");
  a_page_main: assert property (@(posedge sys_clk) disable iff (!rstn)
    regWrite && isReg31 && regWrData == 16'h0000 |=> pageKind == palp_pkg::PG_MAIN)
    else $error("zero write did not restore main page");
  a_page_soft: assert property (@(posedge sys_clk) disable iff (!rstn)
    softReset |=> pageQ == 16'h0000)
    else $error("software reset kept the page");

  // Fiber control, event counters and idle read data.
  a_fiber_inert: assert property (@(posedge sys_clk) disable iff (!rstn)
    !HAS_FIBER |-> txRemoteFault == 2'h0 && !allowFiber1000 && !allowFiber100)
    else $error("fiber control active on copper port");
  a_tx_fault: assert property (@(posedge sys_clk) disable iff (!rstn)
    regWrite && selFiber && !softReset |=> txFaultQ == $past(regWrData[15:14]))
    else $error("remote fault write lost");
  a_lp_fault: assert property (@(posedge sys_clk) disable iff (!rstn)
    regRead && selFiber |=> regRdData[13:12] == $past(partnerRemoteFault))
    else $error("partner remote fault read wrong");
  a_allow_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    regWrite && selFiber |=> fiberAllowQ == $past(regWrData[9:8]))
    else $error("link-up allow write lost");
  a_far_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    HAS_FIBER && farEndFault |=> farFaultQ)
    else $error("far-end fault not captured");
  a_crc_count: assert property (@(posedge sys_clk) disable iff (!rstn)
    goodCrcPacket && !rdCrc && crcCountQ != `PALP_CRC_MODULUS |=> crcCountQ == $past(crcCountQ) + 14'h0001)
    else $error("good CRC counter did not step");
  a_crc_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    goodCrcPacket |=> crcSeenQ)
    else $error("packet flag not set");
  a_crc_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    rdCrc && !goodCrcPacket |=> crcCountQ == 14'h0000 && !crcSeenQ)
    else $error("good CRC counter not cleared by read");
  a_rd_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    !regRead |=> regRdData == 16'h0000)
    else $error("read data outside its cycle");
endmodule

// >>> verif/palp_mgr_model.sv
// Station manager model: one-cycle register writes and reads on the strobe port.
// Assumes the register set samples strobes on the rising edge of sys_clk.
`timescale 1ns/1ps
module palp_mgr_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [4:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [15:0] regRdData
);
  initial begin
    regAddr = 5'h00;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    // Released data is inverted so a stale value never looks valid.
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
    d = regRdData;
  endtask
endmodule

// >>> verif/test_palp_regs.sv
// Self-checking bench for the port register set: link state, events and register traffic.
// Assumes a fiber-capable port 0 at 10 MHz, reached through the station manager model.
`timescale 1ns/1ps
`include "palp_consts.svh"
module test_palp_regs;
  logic sys_clk, rstn, softReset, goodCrcPacket, farEndFault, regWrite, regRead;
  logic stdSpaceSel, gpioPageSel, lowPowerEnable, allowFiber1000, allowFiber100;
  logic [1:0] partnerRemoteFault, localRate, lowPowerTimeout, txRemoteFault, combineDisable;
  logic [3:0] ledOut, ledActive;
  int ledOnCnt, ledZeroCnt;
  logic [4:0] regAddr;
  logic [15:0] regWrData, regRdData, ledModeSel, pageValue;
  palp_pkg::palp_link_type linkState;
  palp_pkg::palp_link_type pats [3] = '{13'h1555, 13'h0AAA, 13'h1F3E};
  int compares = 0;
  int miscompares = 0;
  palp_mgr_model u_mgr (.sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
  palp_regs #(.IS_PORT0(1'b1), .HAS_FIBER(1'b1)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .softReset(softReset), .linkState(linkState),
    .goodCrcPacket(goodCrcPacket), .farEndFault(farEndFault), .partnerRemoteFault(partnerRemoteFault),
    .stdSpaceSel(stdSpaceSel), .gpioPageSel(gpioPageSel), .globalRate(2'h0), .localRate(localRate),
    .ledActive(ledActive), .ledActivity(2'h0), .ledCombineTerm(2'h0), .ledOut(ledOut),
    .ledModeSel(ledModeSel), .lowPowerEnable(lowPowerEnable), .lowPowerTimeout(lowPowerTimeout),
    .txRemoteFault(txRemoteFault), .allowFiber1000(allowFiber1000), .allowFiber100(allowFiber100),
    .combineDisable(combineDisable), .pageValue(pageValue));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] auxExp(palp_pkg::palp_link_type s, logic [2:0] st);
    return {s.anComplete, ~s.anEnable, s.crossover, s.pairCdSwap, s.polaritySwap, st[2], st[1],
      s.duplexStatus, s.speed, st[0], s.media};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    u_mgr.rd(a, v);
    chk(n, e, v);
  endtask
  // Decode outputs are looked at mid-cycle while the read strobe stands.
  task automatic selChk(input logic [4:0] a, input logic [1:0] e);
    logic [15:0] v;
    fork
      u_mgr.rd(a, v);
      begin
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("stdGpioSel", 16'(e), 16'({stdSpaceSel, gpioPageSel}));
      end
    join
  endtask
  task automatic crcPulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      goodCrcPacket <= 1'b1;
    end
    @(posedge sys_clk);
    goodCrcPacket <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    softReset = 1'b0;
    goodCrcPacket = 1'b0;
    farEndFault = 1'b0;
    partnerRemoteFault = 2'h0;
    linkState = '0;
    ledActive = 4'h0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    rdc("ledMode", `PALP_OFS_LED_MODE, 16'h8021);
    rdc("ledBehav", `PALP_OFS_LED_BEHAV, 16'h0400);
    rdc("page", `PALP_OFS_PAGE, 16'h0000);
    $display("test reset values done");
    foreach (pats[i]) begin
      linkState <= pats[i];
      rdc("aux", `PALP_OFS_AUX, auxExp(pats[i], 3'h1));
    end
    u_mgr.wr(`PALP_OFS_AUX, 16'hFFFF);
    rdc("auxSticky", `PALP_OFS_AUX, auxExp(pats[2], 3'h7));
    chk("lowPower", 16'h0007, 16'({lowPowerEnable, lowPowerTimeout}));
    u_mgr.wr(`PALP_OFS_AUX, 16'h0080);
    @(negedge sys_clk);
    chk("lowPower", 16'h0002, 16'({lowPowerEnable, lowPowerTimeout}));
    $display("test aux done");
    u_mgr.wr(`PALP_OFS_LED_BEHAV, 16'hFFFF);
    rdc("ledBehav", `PALP_OFS_LED_BEHAV, 16'h1C63);
    chk("combine", 16'h0003, 16'(combineDisable));
    chk("rate", 16'h0003, 16'(localRate));
    u_mgr.wr(`PALP_OFS_LED_MODE, 16'h1234);
    rdc("ledMode", `PALP_OFS_LED_MODE, 16'h1234);
    chk("ledModeSel", 16'h1234, ledModeSel);
    // Pulsing is on and combining is off here: over one full pulse period half the cycles are lit.
    ledActive <= 4'hF;
    repeat (2) @(posedge sys_clk);
    ledOnCnt = 0;
    ledZeroCnt = 0;
    repeat (2000) begin
      @(negedge sys_clk);
      ledOnCnt += ledOut[3];
      ledZeroCnt += ledOut[0];
    end
    chk("ledPulse", 16'h03E8, 16'(ledOnCnt));
    chk("ledCombineOff", 16'h03E8, 16'(ledZeroCnt));
    ledActive <= 4'h0;
    $display("test led done");
    u_mgr.wr(`PALP_OFS_PAGE, 16'h0001);
    rdc("ext1Reg29", `PALP_OFS_LED_MODE, 16'h0000);
    selChk(5'h03, 2'h2);
    crcPulses(3);
    rdc("crc", `PALP_OFS_GOOD_CRC, 16'h8003);
    rdc("crcCleared", `PALP_OFS_GOOD_CRC, 16'h0000);
    crcPulses(10001);
    rdc("crcWrap", `PALP_OFS_GOOD_CRC, 16'h8001);
    $display("test crc done");
    rdc("fiber", `PALP_OFS_FIBER_CTRL, 16'h0300);
    partnerRemoteFault <= 2'h2;
    u_mgr.wr(`PALP_OFS_FIBER_CTRL, 16'hC000);
    rdc("fiber", `PALP_OFS_FIBER_CTRL, 16'hE000);
    chk("txFault", 16'h0003, 16'(txRemoteFault));
    chk("allow", 16'h0000, 16'({allowFiber1000, allowFiber100}));
    u_mgr.wr(`PALP_OFS_FIBER_CTRL, 16'h4300);
    @(posedge sys_clk);
    farEndFault <= 1'b1;
    @(posedge sys_clk);
    farEndFault <= 1'b0;
    rdc("farEnd", `PALP_OFS_FIBER_CTRL, 16'h6340);
    rdc("farEndCleared", `PALP_OFS_FIBER_CTRL, 16'h6300);
    $display("test fiber done");
    u_mgr.wr(`PALP_OFS_PAGE, 16'h0010);
    selChk(5'h03, 2'h1);
    rdc("gpioReg28", `PALP_OFS_AUX, 16'h0000);
    u_mgr.wr(`PALP_OFS_PAGE, 16'h0002);
    rdc("ext2Reg29", `PALP_OFS_LED_MODE, 16'h0000);
    u_mgr.wr(`PALP_OFS_PAGE, 16'h0000);
    rdc("mainReg29", `PALP_OFS_LED_MODE, 16'h1234);
    $display("test page done");
    u_mgr.wr(`PALP_OFS_PAGE, 16'h0001);
    @(posedge sys_clk);
    softReset <= 1'b1;
    @(posedge sys_clk);
    softReset <= 1'b0;
    @(negedge sys_clk);
    chk("pageSoft", 16'h0000, pageValue);
    chk("txFaultSoft", 16'h0000, 16'(txRemoteFault));
    rdc("ledModeSoft", `PALP_OFS_LED_MODE, 16'h1234);
    rdc("auxSoft", `PALP_OFS_AUX, auxExp(pats[2], 3'h4));
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rdc("ledModeHard", `PALP_OFS_LED_MODE, 16'h8021);
    $display("test resets done");
    wrap_up();
  end
endmodule
